// ### common/cipc_pkg.sv
// Purpose: shared constants and types of the cpu interrupt priority controller
// Assumes: registers are reached by byte address, four times the word index, over a 32-bit bus
// Notes: all offsets, field positions, reset values and counts live here
package cipc_pkg;

    // =====================================================================
    // vector space
    localparam int NUM_VEC = 64;
    localparam int VEC_W = 8;
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_NMI = 8'h01;
    localparam logic [7:0] VEC_NONE = 8'h00;

    // compact table vector numbers
    localparam logic [7:0] CT_VEC_NMI = 8'h01;
    localparam logic [7:0] CT_VEC_LEVEL_ONE = 8'h02;
    localparam logic [7:0] CT_VEC_LEVEL_ZERO = 8'h03;

    // =====================================================================
    // register map: printed index, byte address is four times it
    localparam int ADDR_W = 4;
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_STATUS = 2'h1;
    localparam logic [1:0] IDX_PRIO_PTR = 2'h2;
    localparam logic [1:0] IDX_HP_VEC = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PRIO_PTR = {IDX_PRIO_PTR, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_HP_VEC = {IDX_HP_VEC, 2'h0};

    // =====================================================================
    // field positions
    localparam int CTRL_RR_BIT = 0;
    localparam int CTRL_CVT_BIT = 5;
    localparam int CTRL_VSEL_BIT = 6;
    localparam int STAT_LEVEL_ZERO_BIT = 0;
    localparam int STAT_LEVEL_ONE_BIT = 1;
    localparam int STAT_NMI_BIT = 7;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] PRIO_PTR_RST = 8'h00;
    localparam logic [7:0] HP_VEC_RST = 8'h00;

    // protected write window, in retired instructions
    localparam logic [2:0] UNLOCK_INSTR = 3'h4;

    // =====================================================================
    // types
    typedef enum logic [1:0] {
        CIPC_LVL_NONE,
        CIPC_LVL_ZERO,
        CIPC_LVL_ONE,
        CIPC_LVL_NMI
    } cipc_level_t;

    typedef enum logic {
        CIPC_BUS_IDLE,
        CIPC_BUS_ANSWER
    } cipc_bus_state_t;

    typedef struct packed {
        logic vector_location_select;
        logic compact_table_enable;
        logic round_robin_enable;
    } cipc_ctrl_t;

    typedef struct packed {
        logic non_maskable_executing;
        logic high_level_executing;
        logic normal_level_executing;
    } cipc_exec_t;

    typedef struct packed {
        cipc_level_t level;
        logic [7:0] vector;
        logic [7:0] raw_vector;
    } cipc_offer_t;

endpackage

// ### hdl/cipc_level_zero_pick.sv
// Purpose: picks the winning level-zero request after the priority pointer
// Assumes: requests are already stripped of reset, nmi and level-one vectors
// Notes: result is registered, one cycle behind the inputs
`timescale 1ns/1ps
module cipc_level_zero_pick (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // requests and pointer
    input wire logic [cipc_pkg::NUM_VEC-1:0] i_req,
    input wire logic [7:0] i_ptr,
    // winner
    output logic o_valid,
    output logic [7:0] o_vec
);

    // =====================================================================
    // search: first pending vector after the pointer, wrapping
    function automatic logic [8:0] first_after(
        input logic [cipc_pkg::NUM_VEC-1:0] req,
        input logic [7:0] ptr
    );
        logic [8:0] found;
        logic [7:0] idx;
        found = 9'h000;
        idx = 8'h00;
        for (int k = 256; k >= 1; k--) begin
            idx = 8'(ptr + 8'(k));
            if ((int'(idx) < cipc_pkg::NUM_VEC) && req[idx[5:0]]) begin
                found = {1'b1, idx};
            end
        end
        return found;
    endfunction

    logic [8:0] next_pick;

    always_comb begin
        next_pick = first_after(i_req, i_ptr);
    end

    // =====================================================================
    // registered result
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_valid <= 1'b0;
            o_vec <= cipc_pkg::VEC_NONE;
        end else begin
            o_valid <= next_pick[8];
            o_vec <= next_pick[7:0];
        end
    end

endmodule

// ### hdl/cipc_ctrl.sv
// Purpose: cpu interrupt priority controller with its register file
// Assumes: cpu core pulses acknowledge, return, unlock key and retire
// Notes: Avalon-MM slave, writes in one cycle, reads answer one cycle later
// What this block does
// - vector location bit selects application (0) or boot (1) flash table.
// - compact table bit enables compact vector table mode when set.
// - location and compact bits change only after the unlock sequence.
// - round-robin enable bit is writable directly, no unlock needed.
// - round-robin bit 0 gives fixed order, 1 gives round-robin for level zero.
// - non-maskable executing flag, bit 7, set while its handler runs.
// - high level executing flag, bit 1, stays set while preempted by nmi.
// - normal level executing flag, bit 0, stays set while preempted.
// - each flag clears on its interrupt return; all flags read-only.
// - 8-bit priority pointer holds a vector number, readable and writable.
// - 8-bit high-priority vector register names the vector promoted to level one.
// - high-priority vector zero disables level one entirely.
// - all four registers read zero after reset.
// - compact mode uses vectors 1 nmi, 2 level one, 3 all level zero.
// - pointer vector gets lowest level-zero priority, next gets highest, wrapping.
// - in round-robin, hardware loads pointer with last acknowledged level-zero vector.
// - protected bit written within four instructions after unlock, else unchanged.
`timescale 1ns/1ps
module cipc_ctrl (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // register bus
    input wire logic [cipc_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // interrupt requests
    input wire logic [cipc_pkg::NUM_VEC-1:0] i_irq_req,
    input wire logic i_nmi_req,
    input wire logic i_global_enable,
    // cpu core events
    input wire logic i_int_ack,
    input wire logic i_int_return,
    input wire logic i_unlock,
    input wire logic i_instr_retire,
    // offer to the cpu core
    output logic o_int_req,
    output logic [7:0] o_int_vector,
    output cipc_pkg::cipc_level_t o_int_level,
    // table placement
    output logic o_vector_boot,
    output logic o_compact_table
);

    // =====================================================================
    // state
    cipc_pkg::cipc_ctrl_t ctrl;
    cipc_pkg::cipc_exec_t exec;
    cipc_pkg::cipc_offer_t offer;
    cipc_pkg::cipc_offer_t next_offer;
    cipc_pkg::cipc_bus_state_t bus_state;
    logic [7:0] prio_ptr;
    logic [7:0] hp_vec;
    logic [2:0] unlock_cnt;
    logic [cipc_pkg::NUM_VEC-1:0] level_zero_req;
    logic pick_valid;
    logic [7:0] pick_vec;
    logic hp_pending;
    logic wr_ok;
    logic wr_ctrl;
    logic took;
    logic [7:0] next_rdata;

    // =====================================================================
    // bus decode
    always_comb begin
        wr_ok = i_avs_write && i_avs_byteenable[0];
        wr_ctrl = wr_ok && (i_avs_address == cipc_pkg::ADDR_CTRL);
    end

    assign o_avs_waitrequest = i_avs_read && (bus_state == cipc_pkg::CIPC_BUS_IDLE);

    // =====================================================================
    // protected write window
    // four instruction window
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            unlock_cnt <= 3'h0;
        end else if (i_unlock) begin
            unlock_cnt <= cipc_pkg::UNLOCK_INSTR;
        end else if (i_instr_retire && (unlock_cnt != 3'h0)) begin
            unlock_cnt <= unlock_cnt - 3'h1;
        end
    end

    // =====================================================================
    // control register
    // zero after reset
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl <= '0;
        end else if (wr_ctrl) begin
            ctrl.round_robin_enable <= i_avs_writedata[cipc_pkg::CTRL_RR_BIT];
            if (unlock_cnt != 3'h0) begin
                ctrl.vector_location_select <= i_avs_writedata[cipc_pkg::CTRL_VSEL_BIT];
                ctrl.compact_table_enable <= i_avs_writedata[cipc_pkg::CTRL_CVT_BIT];
            end
        end
    end

    assign o_vector_boot = ctrl.vector_location_select;
    assign o_compact_table = ctrl.compact_table_enable;

    // =====================================================================
    // priority pointer and high-priority vector
    // pointer read and write
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            prio_ptr <= cipc_pkg::PRIO_PTR_RST;
        end else if (took && (offer.level == cipc_pkg::CIPC_LVL_ZERO)
                     && ctrl.round_robin_enable) begin
            prio_ptr <= offer.raw_vector;
        end else if (wr_ok && (i_avs_address == cipc_pkg::ADDR_PRIO_PTR)) begin
            prio_ptr <= i_avs_writedata[7:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            hp_vec <= cipc_pkg::HP_VEC_RST;
        end else if (wr_ok && (i_avs_address == cipc_pkg::ADDR_HP_VEC)) begin
            hp_vec <= i_avs_writedata[7:0];
        end
    end

    // =====================================================================
    // request sorting
    always_comb begin
        level_zero_req = i_irq_req;
        level_zero_req[cipc_pkg::VEC_RESET[5:0]] = 1'b0;
        level_zero_req[cipc_pkg::VEC_NMI[5:0]] = 1'b0;
        hp_pending = 1'b0;
        if ((hp_vec != cipc_pkg::VEC_NONE) && (int'(hp_vec) < cipc_pkg::NUM_VEC)) begin
            hp_pending = i_irq_req[hp_vec[5:0]];
            level_zero_req[hp_vec[5:0]] = 1'b0;
        end
    end

    cipc_level_zero_pick u_pick (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_req(level_zero_req),
        .i_ptr(prio_ptr),
        .o_valid(pick_valid),
        .o_vec(pick_vec)
    );

    // =====================================================================
    // offer to the core
    always_comb begin
        next_offer.level = cipc_pkg::CIPC_LVL_NONE;
        next_offer.vector = cipc_pkg::VEC_NONE;
        next_offer.raw_vector = cipc_pkg::VEC_NONE;
        if (i_nmi_req && !exec.non_maskable_executing) begin
            next_offer.level = cipc_pkg::CIPC_LVL_NMI;
            next_offer.raw_vector = cipc_pkg::VEC_NMI;
        end else if (i_global_enable && hp_pending && !exec.non_maskable_executing
                     && !exec.high_level_executing) begin
            next_offer.level = cipc_pkg::CIPC_LVL_ONE;
            next_offer.raw_vector = hp_vec;
        end else if (i_global_enable && pick_valid && (exec == '0)) begin
            next_offer.level = cipc_pkg::CIPC_LVL_ZERO;
            next_offer.raw_vector = pick_vec;
        end
        if (i_int_ack) begin
            next_offer.level = cipc_pkg::CIPC_LVL_NONE;
        end
        case (next_offer.level)
            cipc_pkg::CIPC_LVL_NMI: begin
                next_offer.vector = ctrl.compact_table_enable ? cipc_pkg::CT_VEC_NMI
                                                              : next_offer.raw_vector;
            end
            cipc_pkg::CIPC_LVL_ONE: begin
                next_offer.vector = ctrl.compact_table_enable ? cipc_pkg::CT_VEC_LEVEL_ONE
                                                              : next_offer.raw_vector;
            end
            cipc_pkg::CIPC_LVL_ZERO: begin
                next_offer.vector = ctrl.compact_table_enable ? cipc_pkg::CT_VEC_LEVEL_ZERO
                                                              : next_offer.raw_vector;
            end
            default: begin
                next_offer.vector = cipc_pkg::VEC_NONE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            offer <= '0;
        end else begin
            offer <= next_offer;
        end
    end

    assign o_int_req = (offer.level != cipc_pkg::CIPC_LVL_NONE);
    assign o_int_vector = offer.vector;
    assign o_int_level = offer.level;
    assign took = i_int_ack && o_int_req;

    // =====================================================================
    // executing flags
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            exec <= '0;
        end else begin
            if (i_int_return) begin
                if (exec.non_maskable_executing) begin
                    exec.non_maskable_executing <= 1'b0;
                end else if (exec.high_level_executing) begin
                    exec.high_level_executing <= 1'b0;
                end else begin
                    exec.normal_level_executing <= 1'b0;
                end
            end
            if (took) begin
                case (offer.level)
                    cipc_pkg::CIPC_LVL_NMI: begin
                        exec.non_maskable_executing <= 1'b1;
                    end
                    cipc_pkg::CIPC_LVL_ONE: begin
                        exec.high_level_executing <= 1'b1;
                    end
                    cipc_pkg::CIPC_LVL_ZERO: begin
                        exec.normal_level_executing <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // read path
    always_comb begin
        next_rdata = 8'h00;
        case (i_avs_address)
            cipc_pkg::ADDR_CTRL: begin
                next_rdata[cipc_pkg::CTRL_VSEL_BIT] = ctrl.vector_location_select;
                next_rdata[cipc_pkg::CTRL_CVT_BIT] = ctrl.compact_table_enable;
                next_rdata[cipc_pkg::CTRL_RR_BIT] = ctrl.round_robin_enable;
            end
            cipc_pkg::ADDR_STATUS: begin
                next_rdata[cipc_pkg::STAT_NMI_BIT] = exec.non_maskable_executing;
                next_rdata[cipc_pkg::STAT_LEVEL_ONE_BIT] = exec.high_level_executing;
                next_rdata[cipc_pkg::STAT_LEVEL_ZERO_BIT] = exec.normal_level_executing;
            end
            cipc_pkg::ADDR_PRIO_PTR: begin
                next_rdata = prio_ptr;
            end
            cipc_pkg::ADDR_HP_VEC: begin
                next_rdata = hp_vec;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_state <= cipc_pkg::CIPC_BUS_IDLE;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            case (bus_state)
                cipc_pkg::CIPC_BUS_IDLE: begin
                    if (i_avs_read) begin
                        bus_state <= cipc_pkg::CIPC_BUS_ANSWER;
                        o_avs_readdata <= {24'h00_0000, next_rdata};
                    end
                end
                default: begin
                    bus_state <= cipc_pkg::CIPC_BUS_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // checks
    a_protected_bits:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $changed(ctrl.compact_table_enable) || $changed(ctrl.vector_location_select)
        |-> $past(unlock_cnt) != 3'h0 && $past(wr_ctrl))
        else $error("protected control bit changed without unlock");

    a_unlock_expires:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_unlock ##1 (!i_unlock && i_instr_retire) [*4] |=> unlock_cnt == 3'h0)
        else $error("unlock window outlived four instructions");

    a_rr_direct_write:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        wr_ctrl |=> ctrl.round_robin_enable == $past(i_avs_writedata[0]))
        else $error("round robin bit not written directly");

    a_nmi_flag_set:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        took && offer.level == cipc_pkg::CIPC_LVL_NMI |=> exec.non_maskable_executing)
        else $error("nmi executing flag not set on entry");

    a_level_one_kept_preempt:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        exec.high_level_executing && exec.non_maskable_executing && i_int_return
        |=> exec.high_level_executing && !exec.non_maskable_executing)
        else $error("level one flag lost under nmi return");

    a_level_zero_kept_preempt:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        exec.normal_level_executing && exec.high_level_executing && i_int_return
        |=> exec.normal_level_executing)
        else $error("level zero flag cleared while preempted");

    a_level1_disabled:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $past(hp_vec) == cipc_pkg::VEC_NONE |-> offer.level != cipc_pkg::CIPC_LVL_ONE)
        else $error("level one offered with selector zero");

    a_compact_level_zero:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_int_level == cipc_pkg::CIPC_LVL_ZERO && $past(ctrl.compact_table_enable)
        |-> o_int_vector == cipc_pkg::CT_VEC_LEVEL_ZERO)
        else $error("compact level zero vector wrong");

    a_rr_pointer_load:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
        took && offer.level == cipc_pkg::CIPC_LVL_ZERO && ctrl.round_robin_enable
        |=> prio_ptr == $past(offer.raw_vector))
        else $error("round robin pointer not loaded");

endmodule

// ### test/cipc_core_model.sv
// Purpose: cpu core model that takes interrupt offers
// Assumes: one ack pulse per offer, after a bench-set delay
// Notes: keeps vector, level and count of taken offers
`timescale 1ns/1ps
module cipc_core_model (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // offer from the controller
    input wire logic i_int_req,
    input wire logic [7:0] i_int_vector,
    input wire cipc_pkg::cipc_level_t i_int_level,
    // bench control
    input wire logic [1:0] i_delay,
    // acknowledge and record
    output logic o_int_ack,
    output logic [7:0] o_last_vec,
    output cipc_pkg::cipc_level_t o_last_level,
    output logic [15:0] o_acks
);
    logic [1:0] wait_cnt;
    // ========
    // take offer after delay
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_int_ack <= 1'b0;
            wait_cnt <= 2'h0;
            o_last_vec <= 8'h00;
            o_last_level <= cipc_pkg::CIPC_LVL_NONE;
            o_acks <= 16'h0000;
        end else begin
            o_int_ack <= 1'b0;
            wait_cnt <= 2'h0;
            if (o_int_ack && i_int_req) begin
                o_last_vec <= i_int_vector;
                o_last_level <= i_int_level;
                o_acks <= o_acks + 16'h0001;
            end
            if (i_int_req && !o_int_ack) begin
                o_int_ack <= (wait_cnt == i_delay);
                wait_cnt <= (wait_cnt == i_delay) ? 2'h0 : wait_cnt + 2'h1;
            end
        end
    end
endmodule

// ### test/cipc_ctrl_tb.sv
// Purpose: self-checking bench of the interrupt priority controller
// Assumes: avalon master waits on waitrequest, core model takes offers
// Notes: random requests and pointers from a fixed seed
`timescale 1ns/1ps
module cipc_ctrl_tb;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [cipc_pkg::ADDR_W-1:0] i_avs_address = '0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = '0;
    logic [31:0] o_avs_readdata, rd;
    logic o_avs_waitrequest, o_int_req, o_vector_boot, o_compact_table, i_int_ack;
    logic [cipc_pkg::NUM_VEC-1:0] i_irq_req = '0;
    logic i_nmi_req = 1'b0;
    logic i_global_enable = 1'b1;
    logic i_int_return = 1'b0;
    logic i_unlock = 1'b0;
    logic i_instr_retire = 1'b0;
    logic [1:0] ack_delay = 2'h0;
    logic [7:0] o_int_vector, last_vec;
    logic [15:0] acks;
    cipc_pkg::cipc_level_t o_int_level, last_level;
    int miscompares = 0;
    int comparisons = 0;

    always #2 i_mclk = ~i_mclk;

    cipc_ctrl u_dut (
        .i_mclk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable(4'hf), .o_avs_readdata, .o_avs_waitrequest, .i_irq_req, .i_nmi_req,
        .i_global_enable, .i_int_ack, .i_int_return, .i_unlock, .i_instr_retire, .o_int_req,
        .o_int_vector, .o_int_level, .o_vector_boot, .o_compact_table
    );
    cipc_core_model u_core (
        .i_mclk, .i_resetn, .i_int_req(o_int_req), .i_int_vector(o_int_vector),
        .i_int_level(o_int_level), .i_delay(ack_delay), .o_int_ack(i_int_ack),
        .o_last_vec(last_vec), .o_last_level(last_level), .o_acks(acks)
    );

    // ========
    // checking and bus tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [cipc_pkg::ADDR_W-1:0] a, input logic [7:0] d);
        logic busy;
        int n;
        n = 0;
        @(posedge i_mclk);
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        do begin
            @(posedge i_mclk);
            busy = o_avs_waitrequest;
            rd = o_avs_readdata;
            n++;
        end while (busy !== 1'b0);
        chk("wait cycles", 32'(n), w ? 32'h1 : 32'h2);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [cipc_pkg::ADDR_W-1:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input string s, input logic [cipc_pkg::ADDR_W-1:0] a,
                          input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(s, rd, e);
    endtask

    // ========
    // core event tasks
    // key then retires
    task automatic unlock(input int retires);
        @(posedge i_mclk) i_unlock <= 1'b1;
        @(posedge i_mclk) i_unlock <= 1'b0;
        repeat (retires) begin
            i_instr_retire <= 1'b1;
            @(posedge i_mclk);
        end
        i_instr_retire <= 1'b0;
    endtask

    task automatic drop_and_return(input int n);
        i_nmi_req <= 1'b0;
        i_irq_req <= '0;
        i_global_enable <= 1'b1;
        repeat (4) @(posedge i_mclk);
        repeat (n) begin
            @(posedge i_mclk) i_int_return <= 1'b1;
            @(posedge i_mclk) i_int_return <= 1'b0;
        end
    endtask

    task automatic wait_ack(input string s, input logic [7:0] ev, input logic [1:0] el);
        logic [15:0] n0;
        n0 = acks;
        while (acks === n0) begin
            @(posedge i_mclk);
        end
        chk({s, " vector"}, {24'h0, last_vec}, {24'h0, ev});
        chk({s, " level"}, {30'h0, last_level}, {30'h0, el});
    endtask

    function automatic logic [7:0] pick(input logic [63:0] r, input logic [7:0] p);
        logic [7:0] v;
        for (int i = 1; i <= 64; i++) begin
            v = 8'((int'(p) + i) % 64);
            if (r[v[5:0]] && v > 8'h01) return v;
        end
        return 8'h00;
    endfunction

    // ========
    // nested levels, plain or compact numbers
    task automatic levels(input logic ct);
        logic [7:0] h;
        logic [7:0] l;
        h = 8'(2 + $urandom % 62);
        l = (h == 8'd63) ? 8'd2 : h + 8'd1;
        wr(cipc_pkg::ADDR_HP_VEC, h);
        i_irq_req <= 64'h1 << l;
        wait_ack("l0", ct ? cipc_pkg::CT_VEC_LEVEL_ZERO : l, cipc_pkg::CIPC_LVL_ZERO);
        rd_chk("flags l0", cipc_pkg::ADDR_STATUS, 32'h01);
        i_irq_req <= (64'h1 << l) | (64'h1 << h);
        wait_ack("l1", ct ? cipc_pkg::CT_VEC_LEVEL_ONE : h, cipc_pkg::CIPC_LVL_ONE);
        rd_chk("flags l1", cipc_pkg::ADDR_STATUS, 32'h03);
        i_nmi_req <= 1'b1;
        wait_ack("nmi", cipc_pkg::CT_VEC_NMI, cipc_pkg::CIPC_LVL_NMI);
        rd_chk("flags nmi", cipc_pkg::ADDR_STATUS, 32'h83);
        drop_and_return(1);
        rd_chk("ret nmi", cipc_pkg::ADDR_STATUS, 32'h03);
        drop_and_return(1);
        rd_chk("ret l1", cipc_pkg::ADDR_STATUS, 32'h01);
        drop_and_return(1);
        rd_chk("ret l0", cipc_pkg::ADDR_STATUS, 32'h00);
        wr(cipc_pkg::ADDR_HP_VEC, 8'h00);
    endtask

    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_mclk);
        miscompares++;
        end_sim();
    end

    // ========
    // main sequence
    initial begin
        logic [7:0] p;
        logic [63:0] r;
        void'($urandom(32'hb9c9));
        repeat (3) @(posedge i_mclk);
        i_resetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rd_chk("reset value", 4'(k * 4), 32'h0);
        end
        rd_chk("unmapped", 4'h2, 32'h0);
        wr(cipc_pkg::ADDR_STATUS, 8'hff);
        rd_chk("flags write", cipc_pkg::ADDR_STATUS, 32'h0);
        for (int k = 0; k < 4; k++) begin
            p = (k == 0) ? 8'hff : 8'($urandom);
            wr(cipc_pkg::ADDR_PRIO_PTR, p);
            wr(cipc_pkg::ADDR_HP_VEC, ~p);
            rd_chk("pointer rw", cipc_pkg::ADDR_PRIO_PTR, {24'h0, p});
            rd_chk("promote rw", cipc_pkg::ADDR_HP_VEC, {24'h0, ~p});
        end
        wr(cipc_pkg::ADDR_HP_VEC, 8'h00);
        for (int k = 0; k < 10; k++) begin
            p = (k == 0) ? 8'd63 : (k == 1) ? 8'd0 : 8'(2 + $urandom % 62);
            r = {$urandom, $urandom} & ~64'h3;
            r = r | (64'h1 << (2 + $urandom % 62));
            ack_delay <= 2'($urandom);
            wr(cipc_pkg::ADDR_CTRL, 8'(k % 2));
            wr(cipc_pkg::ADDR_PRIO_PTR, p);
            i_irq_req <= r;
            wait_ack("sched", pick(r, p), cipc_pkg::CIPC_LVL_ZERO);
            rd_chk("pointer", cipc_pkg::ADDR_PRIO_PTR, {24'h0, (k % 2) ? pick(r, p) : p});
            drop_and_return(1);
            rd_chk("sched ret", cipc_pkg::ADDR_STATUS, 32'h0);
        end
        levels(1'b0);
        i_global_enable <= 1'b0;
        i_irq_req <= 64'h10;
        repeat (6) @(posedge i_mclk);
        chk("gated offer", {31'h0, o_int_req}, 32'h0);
        i_nmi_req <= 1'b1;
        wait_ack("nmi gated", cipc_pkg::VEC_NMI, cipc_pkg::CIPC_LVL_NMI);
        drop_and_return(1);
        wr(cipc_pkg::ADDR_CTRL, 8'h61);
        rd_chk("locked", cipc_pkg::ADDR_CTRL, 32'h01);
        chk("boot table", {31'h0, o_vector_boot}, 32'h0);
        unlock(3);
        wr(cipc_pkg::ADDR_CTRL, 8'h60);
        rd_chk("unlocked", cipc_pkg::ADDR_CTRL, 32'h60);
        chk("boot table", {31'h0, o_vector_boot}, 32'h1);
        chk("compact", {31'h0, o_compact_table}, 32'h1);
        unlock(4);
        wr(cipc_pkg::ADDR_CTRL, 8'h01);
        rd_chk("expired", cipc_pkg::ADDR_CTRL, 32'h61);
        levels(1'b1);
        end_sim();
    end
endmodule
